// File: hw/dapw_top.sv
// Dual auxiliary PWM timers with AXI4-Lite register access.
// Assumes mclk_in is the instruction clock and the master keeps AXI rules.
`timescale 1ns/1ps
`default_nettype none
module dapw_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  // AXI4-Lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // Auxiliary PWM levels
  output logic aux_output_zero_out,
  output logic aux_output_one_out,
  // Shared pins: value and output enable
  output logic aux_pin_zero_out,
  output logic aux_pin_zero_oe_out,
  output logic aux_pin_one_out,
  output logic aux_pin_one_oe_out
);
  // Register file
  logic mode_indep;
  logic [7:0] aux_period_zero;
  logic [7:0] aux_period_or_offset_one;
  logic [7:0] aux_on_time_zero;
  logic [7:0] aux_on_time_one;
  logic [7:0] pin_function_select;
  logic [1:0] pin_data_upper;
  logic [7:0] next_aux_period_zero;
  logic [7:0] next_aux_period_or_offset_one;
  logic [7:0] next_aux_on_time_zero;
  logic [7:0] next_aux_on_time_one;
  logic [7:0] next_pin_function_select;
  logic [1:0] next_pin_data_upper;
  logic next_mode_indep;
  // Timing state
  logic phase;
  logic boot;
  logic next_phase;
  logic next_boot;
  logic restart;
  // AXI slave state
  logic aw_held;
  logic [7:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic next_aw_held;
  logic [7:0] next_aw_addr;
  logic next_w_held;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_wr;
  logic per_wr;
  logic mode_chg;

  dapw_chan_if ch_zero ();
  dapw_chan_if ch_one ();

  // Write fires once address and data are both held and no write response is pending
  assign do_wr = aw_held && w_held && !bvalid;
  assign s_axi_awready_out = !aw_held;
  assign s_axi_wready_out = !w_held;
  assign s_axi_arready_out = !rvalid;

  // Write channel and register updates
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_mode_indep = mode_indep;
    next_aux_period_zero = aux_period_zero;
    next_aux_period_or_offset_one = aux_period_or_offset_one;
    next_aux_on_time_zero = aux_on_time_zero;
    next_aux_on_time_one = aux_on_time_one;
    next_pin_function_select = pin_function_select;
    next_pin_data_upper = pin_data_upper;
    per_wr = 1'b0;
    mode_chg = 1'b0;
    if (s_axi_awvalid_in && !aw_held)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !w_held)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_in;
      next_w_strb = s_axi_wstrb_in;
    end
    if (bvalid && s_axi_bready_in)
    begin
      next_bvalid = 1'b0;
    end
    if (do_wr)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = dapw_pkg::RESP_OKAY;
      if (aw_addr == dapw_pkg::OFS_MODE)
      begin
        if (w_strb[1])
        begin
          next_mode_indep = w_data[dapw_pkg::MODE_INDEP_BIT];
          mode_chg = next_mode_indep != mode_indep;
        end
      end
      else if (aw_addr == dapw_pkg::OFS_PERIOD_ZERO)
      begin
        if (w_strb[0])
        begin
          next_aux_period_zero = w_data[7:0];
          per_wr = 1'b1;
        end
      end
      else if (aw_addr == dapw_pkg::OFS_PERIOD_ONE)
      begin
        if (w_strb[0])
        begin
          next_aux_period_or_offset_one = w_data[7:0];
          per_wr = 1'b1;
        end
      end
      else if (aw_addr == dapw_pkg::OFS_ON_ZERO)
      begin
        if (w_strb[0])
        begin
          next_aux_on_time_zero = w_data[7:0];
        end
      end
      else if (aw_addr == dapw_pkg::OFS_ON_ONE)
      begin
        if (w_strb[0])
        begin
          next_aux_on_time_one = w_data[7:0];
        end
      end
      else if (aw_addr == dapw_pkg::OFS_PIN_SELECT)
      begin
        if (w_strb[0])
        begin
          next_pin_function_select = w_data[7:0];
        end
      end
      else if (aw_addr == dapw_pkg::OFS_PIN_DATA_UPPER)
      begin
        if (w_strb[0])
        begin
          next_pin_data_upper = w_data[1:0];
        end
      end
      else if (aw_addr == dapw_pkg::OFS_STATUS)
      begin
        next_bresp = dapw_pkg::RESP_OKAY;
      end
      else
      begin
        next_bresp = dapw_pkg::RESP_SLVERR;
      end
    end
  end

  // Read channel decode
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready_in)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp = dapw_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr_in == dapw_pkg::OFS_MODE)
      begin
        next_rdata[dapw_pkg::MODE_INDEP_BIT] = mode_indep;
      end
      else if (s_axi_araddr_in == dapw_pkg::OFS_PERIOD_ZERO)
      begin
        next_rdata[7:0] = aux_period_zero;
      end
      else if (s_axi_araddr_in == dapw_pkg::OFS_PERIOD_ONE)
      begin
        next_rdata[7:0] = aux_period_or_offset_one;
      end
      else if (s_axi_araddr_in == dapw_pkg::OFS_ON_ZERO)
      begin
        next_rdata[7:0] = aux_on_time_zero;
      end
      else if (s_axi_araddr_in == dapw_pkg::OFS_ON_ONE)
      begin
        next_rdata[7:0] = aux_on_time_one;
      end
      else if (s_axi_araddr_in == dapw_pkg::OFS_PIN_SELECT)
      begin
        next_rdata[7:0] = pin_function_select;
      end
      else if (s_axi_araddr_in == dapw_pkg::OFS_PIN_DATA_UPPER)
      begin
        next_rdata[1:0] = pin_data_upper;
      end
      else if (s_axi_araddr_in == dapw_pkg::OFS_STATUS)
      begin
        next_rdata[1:0] = {ch_one.pwm, ch_zero.pwm};
      end
      else
      begin
        next_rresp = dapw_pkg::RESP_SLVERR;
      end
    end
  end

  // Restart on period write, mode change or first cycle after reset
  assign restart = per_wr || mode_chg || boot;

  // Step phase: one step per two instruction clocks
  always_comb
  begin
    next_boot = 1'b0;
    if (restart)
    begin
      next_phase = 1'b0;
    end
    else
    begin
      next_phase = !phase;
    end
  end

  // Channel zero always uses period zero
  assign ch_zero.step = phase;
  assign ch_zero.restart = restart;
  assign ch_zero.clear = 1'b0;
  assign ch_zero.period = aux_period_zero;
  assign ch_zero.on_time = aux_on_time_zero;

  // Channel one: own period, or delayed start sharing period zero
  assign ch_one.step = phase;
  assign ch_one.period = mode_indep ? aux_period_or_offset_one
                                    : aux_period_zero;
  assign ch_one.on_time = aux_on_time_one;
  // Incoming mode decides, so a mode-change restart treats one correctly
  assign ch_one.clear = restart && !next_mode_indep;
  // Start when channel zero moves to offset+1 steps past its rise
  assign ch_one.restart = next_mode_indep ? restart
    : (!restart && phase && ch_zero.count == aux_period_or_offset_one
       && ch_zero.count < aux_period_zero);

  dapw_aux_chan u_chan_zero (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .ch(ch_zero)
  );

  dapw_aux_chan u_chan_one (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .ch(ch_one)
  );

  // Register all state
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      mode_indep <= dapw_pkg::RST_MODE_INDEP;
      aux_period_zero <= dapw_pkg::RST_PERIOD;
      aux_period_or_offset_one <= dapw_pkg::RST_PERIOD;
      aux_on_time_zero <= dapw_pkg::RST_ON_TIME;
      aux_on_time_one <= dapw_pkg::RST_ON_TIME;
      pin_function_select <= dapw_pkg::RST_PIN_SELECT;
      pin_data_upper <= dapw_pkg::RST_PIN_DATA_UPPER;
      phase <= 1'b0;
      boot <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= dapw_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= dapw_pkg::RESP_OKAY;
    end
    else
    begin
      mode_indep <= next_mode_indep;
      aux_period_zero <= next_aux_period_zero;
      aux_period_or_offset_one <= next_aux_period_or_offset_one;
      aux_on_time_zero <= next_aux_on_time_zero;
      aux_on_time_one <= next_aux_on_time_one;
      pin_function_select <= next_pin_function_select;
      pin_data_upper <= next_pin_data_upper;
      phase <= next_phase;
      boot <= next_boot;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Bus outputs
  assign s_axi_bvalid_out = bvalid;
  assign s_axi_bresp_out = bresp;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = rdata;
  assign s_axi_rresp_out = rresp;

  // PWM levels and pin routing; select set releases pin to GPIO
  assign aux_output_zero_out = ch_zero.pwm;
  assign aux_output_one_out = ch_one.pwm;
  assign aux_pin_zero_out = ch_zero.pwm;
  assign aux_pin_zero_oe_out =
    !pin_data_upper[dapw_pkg::PIN_ZERO_SEL_BIT];
  assign aux_pin_one_out = ch_one.pwm;
  assign aux_pin_one_oe_out =
    !pin_function_select[dapw_pkg::PIN_ONE_SEL_BIT];
endmodule : dapw_top
`default_nettype wire

// File: hw/dapw_pkg.sv
// Constants for the dual auxiliary PWM timer block.
// Assumes a 125 MHz mclk_in as the instruction clock and AXI4-Lite access.
// Functional notes
// - Two PWM outputs, each with 8-bit period and 8-bit on-time, on pins.
// - Mode bit 8 set gives independent channels; cleared gives offset mode.
// - Independent: each period register sets own period, value+1 steps.
// - One time step equals two instruction-clock periods.
// - High time equals on-time value in steps; zero gives 0% duty.
// - On-time above period keeps the output high, 100% duty.
// - Offset mode: both outputs use period zero, own on-times kept.
// - Offset mode: register one sets rise-to-rise delay, value+1 steps; values not below period zero keep output one low.
// - Writes any time; new on-time used from next cycle start.
// - Any period register write clears timers and starts new cycles.
// - Reset: offset mode, periods 0xFF, on-times 0x00.
// - Pin select bit set gives GPIO; cleared routes PWM to the pin.
// - Time base is two instruction clock periods.

package dapw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_PERIOD_ZERO = 8'h04;
  localparam logic [7:0] OFS_PERIOD_ONE = 8'h08;
  localparam logic [7:0] OFS_ON_ZERO = 8'h0C;
  localparam logic [7:0] OFS_ON_ONE = 8'h10;
  localparam logic [7:0] OFS_PIN_SELECT = 8'h14;
  localparam logic [7:0] OFS_PIN_DATA_UPPER = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // Field positions
  localparam int MODE_INDEP_BIT = 8;
  localparam int PIN_ONE_SEL_BIT = 7;
  localparam int PIN_ZERO_SEL_BIT = 1;
  // Reset values
  localparam logic RST_MODE_INDEP = 1'b0;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_ON_TIME = 8'h00;
  localparam logic [7:0] RST_PIN_SELECT = 8'hFF;
  localparam logic [1:0] RST_PIN_DATA_UPPER = 2'h2;
  // Timing: clock cycles per time step
  localparam int STEP_CYCLES = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dapw_pkg

// File: hw/dapw_chan_if.sv
// Interface between the timer control and one PWM channel.
// Assumes the control end drives steps, restarts and settings.
`timescale 1ns/1ps
`default_nettype none
interface dapw_chan_if;
  logic step;
  logic restart;
  logic clear;
  logic [7:0] period;
  logic [7:0] on_time;
  logic [7:0] count;
  logic pwm;
  modport chan (input step, restart, clear, period, on_time,
                output count, pwm);
  modport ctl (output step, restart, clear, period, on_time,
               input count, pwm);
endinterface : dapw_chan_if
`default_nettype wire

// File: hw/dapw_aux_chan.sv
// One auxiliary PWM channel: step counter, on-time latch, output flop.
// Assumes step pulses once per time step and restart/clear from control.
`timescale 1ns/1ps
`default_nettype none
module dapw_aux_chan (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Control side
  dapw_chan_if.chan ch
);
  logic [7:0] cnt;
  logic [7:0] on_lat;
  logic run;
  logic pwm;
  logic [7:0] next_cnt;
  logic [7:0] next_on_lat;
  logic next_run;
  logic next_pwm;

  // Next counter, latch and output
  always_comb
  begin
    next_cnt = cnt;
    next_on_lat = on_lat;
    next_run = run;
    if (ch.clear)
    begin
      next_cnt = 8'h00;
      next_run = 1'b0;
    end
    else if (ch.restart)
    begin
      next_cnt = 8'h00;
      next_on_lat = ch.on_time;
      next_run = 1'b1;
    end
    else if (ch.step && run)
    begin
      if (cnt >= ch.period)
      begin
        next_cnt = 8'h00;
        next_on_lat = ch.on_time;
      end
      else
      begin
        next_cnt = cnt + 8'h01;
      end
    end
    // High from cycle start for on-time steps; above period stays high
    next_pwm = next_run && (next_cnt < next_on_lat);
  end

  // Channel state registers
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      cnt <= 8'h00;
      on_lat <= dapw_pkg::RST_ON_TIME;
      run <= 1'b0;
      pwm <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      on_lat <= next_on_lat;
      run <= next_run;
      pwm <= next_pwm;
    end
  end

  assign ch.count = cnt;
  assign ch.pwm = pwm;
endmodule : dapw_aux_chan
`default_nettype wire

// File: sim/dapw_props.sv
// Port checker for the dual auxiliary PWM timer block.
// Assumes it is bound into dapw_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module dapw_props (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Register bus handshakes
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  // PWM levels and shared pins
  input wire logic aux_output_zero_out,
  input wire logic aux_output_one_out,
  input wire logic aux_pin_zero_out,
  input wire logic aux_pin_zero_oe_out,
  input wire logic aux_pin_one_out,
  input wire logic aux_pin_one_oe_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  // Idle bus and quiet pins straight out of reset
  a_ready_after_rst: assert property ($past(sys_rst_in) |->
    s_axi_awready_out && s_axi_arready_out && !s_axi_bvalid_out &&
    !aux_output_zero_out && !aux_pin_zero_oe_out && !aux_pin_one_oe_out)
    else $error("bus or pins not idle after reset");
  // Answers stand until taken
  a_bvalid_holds: assert property (
    s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  a_rvalid_holds: assert property (
    s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  a_read_blocks: assert property (
    s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address taken while data pending");
  a_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_write_answer: assert property (
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |-> ##2 s_axi_bvalid_out)
    else $error("write answer late");
  a_addr_held: assert property (
    s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
    else $error("second address taken during a write");
  // Routed pins carry the PWM levels
  a_pin_zero_level: assert property (
    aux_pin_zero_oe_out |-> aux_pin_zero_out == aux_output_zero_out)
    else $error("pin zero does not follow output zero");
  a_pin_one_level: assert property (
    aux_pin_one_oe_out |-> aux_pin_one_out == aux_output_one_out)
    else $error("pin one does not follow output one");
endmodule : dapw_props

bind dapw_top dapw_props dapw_props_i (.mclk_in, .sys_rst_in,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out,
  .aux_output_zero_out, .aux_output_one_out, .aux_pin_zero_out,
  .aux_pin_zero_oe_out, .aux_pin_one_out, .aux_pin_one_oe_out);
`default_nettype wire

// File: sim/dapw_filter_model.sv
// Filter network model that times the two PWM trains it receives.
// Assumes the pulse trains change only on rising edges of mclk_in.
`timescale 1ns/1ps
`default_nettype none
module dapw_filter_model (
  // Clock
  input wire logic mclk_in,
  // Pulse trains from the device
  input wire logic [1:0] pwm_in,
  // Last rise stamp, period and high time, in clocks
  output var int rise_at_out [2],
  output var int period_out [2],
  output var int high_out [2]
);
  int cyc = 0;
  logic [1:0] last = 2'h0;

  // Stamp every edge; unknown levels count as low
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    last <= pwm_in;
    for (int i = 0; i < 2; i++)
    begin
      if (pwm_in[i] === 1'b1 && last[i] !== 1'b1)
      begin
        period_out[i] <= cyc - rise_at_out[i];
        rise_at_out[i] <= cyc;
      end
      if (pwm_in[i] !== 1'b1 && last[i] === 1'b1)
        high_out[i] <= cyc - rise_at_out[i];
    end
  end
endmodule : dapw_filter_model
`default_nettype wire

// File: sim/dapw_top_tb.sv
// Self-checking bench for the dual auxiliary PWM timers.
// Assumes the filter model times outputs; bus answers are queued notes.
`timescale 1ns/1ps
`default_nettype none
module dapw_top_tb;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, o0, o1, e0, e1;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] q [$];
  logic [33:0] note;
  logic [31:0] rstv [8] = '{32'h0, 32'hFF, 32'hFF, 32'h0, 32'h0,
    32'hFF, 32'h2, 32'h0};
  int fails = 0, n_checks = 0, seed = 32'hf9b79cbb;
  bit lazy = 1'b1;
  int v0, v1, c0, c1, t;
  int ra [2], per [2], hi [2];

  dapw_top dapw_top_i (.mclk_in, .sys_rst_in,
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .aux_output_zero_out(o0),
    .aux_output_one_out(o1), .aux_pin_zero_out(),
    .aux_pin_zero_oe_out(e0), .aux_pin_one_out(),
    .aux_pin_one_oe_out(e1));
  dapw_filter_model dapw_filter_model_i (.mclk_in, .pwm_in({o1, o0}),
    .rise_at_out(ra), .period_out(per), .high_out(hi));

  // 125 MHz clock
  initial forever #4 mclk_in = ~mclk_in;

  function automatic int rnd(input int m);
    return $unsigned($random(seed)) % m;
  endfunction : rnd

  task automatic chk(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One bus transfer; ready sometimes raised only once the answer stands
  task automatic bus(input bit w, input logic [7:0] a,
    input logic [31:0] d, input logic [1:0] r, input logic [31:0] e);
    bit ta, tw, tb, tv, lz;
    lz = lazy && rnd(2) == 1;
    q.push_back({r, e});
    @(posedge mclk_in);
    awvalid <= w;
    wvalid <= w;
    bready <= w && !lz;
    arvalid <= !w;
    rready <= !w && !lz;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    do
    begin
      @(negedge mclk_in);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      tb = (bvalid && bready) || (rvalid && rready);
      tv = bvalid || rvalid;
      @(posedge mclk_in);
      if (ta) {awvalid, arvalid} <= 2'b00;
      if (tw) wvalid <= 1'b0;
      if (tb) {bready, rready} <= 2'b00;
      else if (tv) {bready, rready} <= {w, !w};
    end while (!tb);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, dapw_pkg::RESP_OKAY, 32'h0);
  endtask : wr

  task automatic do_reset();
    sys_rst_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    chk("oe_rst", {e1, e0}, 2'b00);
    for (int i = 0; i < 8; i++)
      bus(1'b0, 8'(4 * i), 32'h0, dapw_pkg::RESP_OKAY, rstv[i]);
  endtask : do_reset

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Oldest note against each bus answer
  always @(negedge mclk_in)
  begin
    if ((bvalid && bready) || (rvalid && rready))
    begin
      note = q.pop_front();
      chk("resp", bvalid ? bresp : rresp, note[33:32]);
      if (rvalid && note[33:32] == dapw_pkg::RESP_OKAY)
        chk("rdata", rdata, note[31:0]);
    end
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    fails++;
    give_verdict();
  end

  initial
  begin
    do_reset();
    bus(1'b1, 8'h20, 32'h5A, dapw_pkg::RESP_SLVERR, 32'h0);
    bus(1'b0, 8'h20, 32'h0, dapw_pkg::RESP_SLVERR, 32'h0);
    // Independent channels with random settings
    v0 = 4 + rnd(40);
    v1 = 4 + rnd(40);
    c0 = 3 + rnd(v0 - 2);
    c1 = 1 + rnd(v1);
    wr(8'h00, 32'h100);
    wr(8'h0C, c0);
    wr(8'h10, c1);
    wr(8'h04, v0);
    wr(8'h08, v1);
    repeat (200) @(posedge mclk_in);
    chk("per0", per[0], 2 * (v0 + 1));
    chk("per1", per[1], 2 * (v1 + 1));
    chk("hi0", hi[0], 2 * c0);
    chk("hi1", hi[1], 2 * c1);
    // On-time written mid-cycle waits for the next cycle
    @(posedge o0);
    wr(8'h0C, v0 + 1);
    @(negedge o0);
    repeat (2) @(posedge mclk_in);
    chk("hi_old", hi[0], 2 * c0);
    wr(8'h10, 32'h0);
    repeat (200) @(posedge mclk_in);
    repeat (2 * v0 + 2) @(negedge mclk_in) chk("duty", {o1, o0}, 2'b01);
    // Offset mode, offset kept below period
    v0 = 8 + rnd(30);
    v1 = rnd(v0);
    c0 = 1 + rnd(v0);
    c1 = 1 + rnd(v0);
    wr(8'h00, 32'h0);
    wr(8'h0C, c0);
    wr(8'h10, c1);
    wr(8'h08, v1);
    lazy = 1'b0;
    wr(8'h04, v0);
    t = 0;
    while (o1 !== 1'b1)
    begin
      @(negedge mclk_in);
      t++;
    end
    chk("restart", t, 2 * (v1 + 1));
    lazy = 1'b1;
    repeat (200) @(posedge mclk_in);
    chk("oper0", per[0], 2 * (v0 + 1));
    chk("oper1", per[1], 2 * (v0 + 1));
    t = ra[1] - ra[0];
    chk("offs", t < 0 ? t + 2 * (v0 + 1) : t, 2 * (v1 + 1));
    chk("ohi1", hi[1], 2 * c1);
    bus(1'b0, 8'h04, 32'h0, dapw_pkg::RESP_OKAY, v0);
    // Route both pins to the PWM outputs
    wr(8'h18, 32'h0);
    wr(8'h14, 32'h7F);
    chk("oe_on", {e1, e0}, 2'b11);
    do_reset();
    give_verdict();
  end
endmodule : dapw_top_tb
`default_nettype wire
